//--- rtl/gpc_pkg.sv
// Shared constants for the general-purpose port block
package gpc_pkg;
   // Bus and port widths, synchronizer depth
   localparam int          ADDR_W          = 10;
   localparam int          DATA_W          = 32;
   localparam int          PORT_W          = 8;
   localparam int          SYNC_STAGES     = 2;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_SP_DATA     = 8'h06;
   localparam logic [7:0]  IDX_TP_DATA     = 8'h07;
   localparam logic [7:0]  IDX_FP_DATA     = 8'h08;
   localparam logic [7:0]  IDX_INT_CTRL    = 8'h0B;
   localparam logic [7:0]  IDX_OPTION      = 8'h81;
   localparam logic [7:0]  IDX_SP_DIR      = 8'h86;
   localparam logic [7:0]  IDX_TP_DIR      = 8'h87;
   localparam logic [7:0]  IDX_FP_DIR      = 8'h88;
   localparam logic [7:0]  IDX_FIFTH_DIR   = 8'h89;
   localparam logic [7:0]  IDX_ANALOG_CFG  = 8'h9F;

   // Field positions
   localparam int          FLAG_BIT        = 0;
   localparam int          CHG_EN_BIT      = 3;
   localparam int          PULL_UP_N_BIT   = 7;
   localparam int          PSP_MODE_BIT    = 4;
   localparam int          CHG_LO          = 4;
   localparam int          CHG_HI          = 7;
   localparam int          SP_EXT_INT_BIT  = 0;
   localparam int          SP_SS_BIT       = 1;
   localparam int          SP_AN8_BIT      = 2;
   localparam int          SP_AN9_BIT      = 3;
   localparam int          SP_PGM_CLK_BIT  = 6;
   localparam int          SP_PGM_DAT_BIT  = 7;
   localparam int          TP_TMR_BIT      = 0;
   localparam int          TP_CAPTURE_COMPARE_TWO_BIT     = 1;
   localparam int          TP_CAPTURE_COMPARE_ONE_BIT     = 2;
   localparam int          TP_SCK_BIT      = 3;
   localparam int          TP_SDI_BIT      = 4;
   localparam int          TP_CK_BIT       = 6;
   localparam int          TP_RX_BIT       = 7;

   // Reset values
   localparam logic [7:0]  RST_LATCH       = 8'h00;
   localparam logic [7:0]  RST_DIR         = 8'hFF;
   localparam logic [7:0]  RST_OPTION      = 8'hFF;
   localparam logic [7:0]  RST_ANALOG      = 8'h00;
   localparam logic [7:0]  RST_INT_CTRL    = 8'h00;
   localparam logic [7:0]  RST_FIFTH_DIR   = 8'h07;
endpackage : gpc_pkg

//--- rtl/gpc_ports.sv
// Second, third and fourth port logic with change detection
`timescale 1ns/1ps
module gpc_ports
   import gpc_pkg::*;
#(
   parameter int FP_PRESENT = 1
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rstn_i,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0]  avs_address_i,
   input  wire logic               avs_read_i,
   input  wire logic               avs_write_i,
   input  wire logic [DATA_W-1:0]  avs_writedata_i,
   input  wire logic [3:0]         avs_byteenable_i,
   output logic      [DATA_W-1:0]  avs_readdata_o,
   output logic                    avs_waitrequest_o,
   // Second port pins
   input  wire logic [PORT_W-1:0]  sp_in_i,
   output logic      [PORT_W-1:0]  sp_out_o,
   output logic      [PORT_W-1:0]  sp_oe_o,
   output logic      [PORT_W-1:0]  sp_pullup_o,
   output logic      [PORT_W-1:0]  sp_schmitt_o,
   // Second port alternate functions
   input  wire logic               ext_int_en_i,
   input  wire logic               ssp_ss_en_i,
   input  wire logic [1:0]         analog_en_i,
   input  wire logic               prog_mode_i,
   output logic                    ext_int_o,
   output logic                    ssp_ss_n_o,
   output logic      [1:0]         analog_connect_o,
   output logic                    prog_clk_o,
   output logic                    prog_data_o,
   output logic      [PORT_W-1:0]  analog_config_o,
   output logic                    change_irq_o,
   // Third port pins
   input  wire logic [PORT_W-1:0]  tp_in_i,
   output logic      [PORT_W-1:0]  tp_out_o,
   output logic      [PORT_W-1:0]  tp_oe_o,
   // Third port peripheral sharing
   input  wire logic [PORT_W-1:0]  tp_periph_en_i,
   input  wire logic [PORT_W-1:0]  tp_periph_oe_i,
   input  wire logic [PORT_W-1:0]  tp_periph_out_i,
   output logic                    timer_clk_in_o,
   output logic                    capture_compare_two_in_o,
   output logic                    capture_compare_one_in_o,
   output logic                    ssp_sck_in_o,
   output logic                    ssp_sdi_o,
   output logic                    usart_ck_in_o,
   output logic                    usart_rx_o,
   // Fourth port pins
   input  wire logic [PORT_W-1:0]  fp_in_i,
   output logic      [PORT_W-1:0]  fp_out_o,
   output logic      [PORT_W-1:0]  fp_oe_o,
   output logic                    fp_ttl_o,
   output logic                    psp_mode_o
);

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a[ADDR_W-1:2] == idx;
   endfunction : reg_hit

   logic                    ack;
   logic                    req;
   logic                    rd_first;
   logic                    wr_lane;
   logic [PORT_W-1:0]       wbyte;
   logic [3*PORT_W-1:0]     sync1;
   logic [3*PORT_W-1:0]     sync2;
   logic [PORT_W-1:0]       sp_sync;
   logic [PORT_W-1:0]       tp_sync;
   logic [PORT_W-1:0]       fp_sync;
   logic [PORT_W-1:0]       sp_latch;
   logic [PORT_W-1:0]       tp_latch;
   logic [PORT_W-1:0]       fp_latch;
   logic [PORT_W-1:0]       sp_dir;
   logic [PORT_W-1:0]       tp_dir;
   logic [PORT_W-1:0]       fp_dir;
   logic [PORT_W-1:0]       fifth_dir;
   logic [PORT_W-1:0]       option_ctl;
   logic [PORT_W-1:0]       analog_cfg;
   logic [PORT_W-1:1]       int_ctl;
   logic                    flag;
   logic                    next_flag;
   logic [CHG_HI:CHG_LO]    snap;
   logic [CHG_HI:CHG_LO]    mism;
   logic [PORT_W-1:0]       sp_read;
   logic [PORT_W-1:0]       rd_mux;
   logic                    wr_sp;
   logic                    wr_int;

   // One wait cycle per access keeps read data a flop output
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack;
   assign rd_first          = avs_read_i & ~ack;
   assign wr_lane           = avs_write_i & ack & avs_byteenable_i[0];
   assign wbyte             = avs_writedata_i[PORT_W-1:0];
   assign wr_sp             = wr_lane & reg_hit(avs_address_i, IDX_SP_DATA);
   assign wr_int            = wr_lane & reg_hit(avs_address_i, IDX_INT_CTRL);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // Second stage alone feeds logic; first stage is read by nothing else
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {fp_in_i, tp_in_i, sp_in_i};
         sync2 <= sync1;
      end
   end

   assign sp_sync = sync2[PORT_W-1:0];
   // Third-port pads are Schmitt only, so no buffer select leaves here
   assign tp_sync = sync2[2*PORT_W-1:PORT_W];
   assign fp_sync = (FP_PRESENT != 0) ? sync2[3*PORT_W-1:2*PORT_W] : '0;

   // Output latches and direction registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sp_latch <= RST_LATCH;
         tp_latch <= RST_LATCH;
         fp_latch <= RST_LATCH;
      end else if (wr_lane) begin
         if (reg_hit(avs_address_i, IDX_SP_DATA)) begin
            sp_latch <= wbyte;
         end
         if (reg_hit(avs_address_i, IDX_TP_DATA)) begin
            tp_latch <= wbyte;
         end
         if (reg_hit(avs_address_i, IDX_FP_DATA)) begin
            fp_latch <= wbyte;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sp_dir    <= RST_DIR;
         tp_dir    <= RST_DIR;
         fp_dir    <= RST_DIR;
         fifth_dir <= RST_FIFTH_DIR;
      end else if (wr_lane) begin
         if (reg_hit(avs_address_i, IDX_SP_DIR)) begin
            sp_dir <= wbyte;
         end
         if (reg_hit(avs_address_i, IDX_TP_DIR)) begin
            tp_dir <= wbyte;
         end
         if (reg_hit(avs_address_i, IDX_FP_DIR)) begin
            fp_dir <= wbyte;
         end
         if (reg_hit(avs_address_i, IDX_FIFTH_DIR)) begin
            fifth_dir <= wbyte;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         option_ctl <= RST_OPTION;
         analog_cfg <= RST_ANALOG;
         int_ctl    <= RST_INT_CTRL[PORT_W-1:1];
      end else if (wr_lane) begin
         if (reg_hit(avs_address_i, IDX_OPTION)) begin
            option_ctl <= wbyte;
         end
         if (reg_hit(avs_address_i, IDX_ANALOG_CFG)) begin
            analog_cfg <= wbyte;
         end
         if (wr_int) begin
            int_ctl <= wbyte[PORT_W-1:1];
         end
      end
   end

   // Change detection on the upper nibble
   assign mism = (sp_sync[CHG_HI:CHG_LO] ^ snap) & sp_dir[CHG_HI:CHG_LO];

   // Copy taken with the same sample that the read returns
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         snap <= '0;
      end else if ((rd_first && reg_hit(avs_address_i, IDX_SP_DATA)) || wr_sp) begin
         snap <= sp_sync[CHG_HI:CHG_LO];
      end
   end

   // A mismatch beats a software clear in the same cycle
   always_comb begin
      next_flag = flag;
      if (wr_int) begin
         next_flag = wbyte[FLAG_BIT];
      end
      if (|mism) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag <= RST_INT_CTRL[FLAG_BIT];
      end else begin
         flag <= next_flag;
      end
   end

   // Level stays up while asleep, so it doubles as the wake request
   assign change_irq_o = flag & int_ctl[CHG_EN_BIT];

   // Analog pins read as zero in the digital path
   always_comb begin
      sp_read             = sp_sync;
      sp_read[SP_AN8_BIT] = sp_sync[SP_AN8_BIT] & ~analog_en_i[0];
      sp_read[SP_AN9_BIT] = sp_sync[SP_AN9_BIT] & ~analog_en_i[1];
   end

   always_comb begin
      rd_mux = '0;
      case (avs_address_i[ADDR_W-1:2])
         IDX_SP_DATA:    rd_mux = sp_read;
         IDX_TP_DATA:    rd_mux = tp_sync;
         IDX_FP_DATA:    rd_mux = fp_sync;
         IDX_INT_CTRL:   rd_mux = {int_ctl, flag};
         IDX_OPTION:     rd_mux = option_ctl;
         IDX_SP_DIR:     rd_mux = sp_dir;
         IDX_TP_DIR:     rd_mux = tp_dir;
         IDX_FP_DIR:     rd_mux = fp_dir;
         IDX_FIFTH_DIR:  rd_mux = fifth_dir;
         IDX_ANALOG_CFG: rd_mux = analog_cfg;
         default:        rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_readdata_o <= '0;
      end else if (rd_first) begin
         avs_readdata_o <= {{(DATA_W-PORT_W){1'b0}}, rd_mux};
      end
   end

   // Second port pads
   assign sp_out_o    = sp_latch;
   assign sp_oe_o     = ~sp_dir;
   assign sp_pullup_o = {PORT_W{~option_ctl[PULL_UP_N_BIT]}} & sp_dir;

   always_comb begin
      sp_schmitt_o                 = '0;
      sp_schmitt_o[SP_EXT_INT_BIT] = ext_int_en_i;
      sp_schmitt_o[SP_SS_BIT]      = ssp_ss_en_i;
      sp_schmitt_o[SP_PGM_CLK_BIT] = prog_mode_i;
      sp_schmitt_o[SP_PGM_DAT_BIT] = prog_mode_i;
   end

   assign ext_int_o        = sp_sync[SP_EXT_INT_BIT];
   assign ssp_ss_n_o       = sp_sync[SP_SS_BIT];
   assign analog_connect_o = analog_en_i & sp_dir[SP_AN9_BIT:SP_AN8_BIT];
   assign prog_clk_o       = sp_sync[SP_PGM_CLK_BIT];
   assign prog_data_o      = sp_sync[SP_PGM_DAT_BIT];
   assign analog_config_o  = analog_cfg;

   // Third port: peripheral wins over direction while enabled
   for (genvar i = 0; i < PORT_W; i++) begin : g_tp
      assign tp_oe_o[i]  = tp_periph_en_i[i] ? tp_periph_oe_i[i] : ~tp_dir[i];
      assign tp_out_o[i] = tp_periph_en_i[i] ? tp_periph_out_i[i] : tp_latch[i];
   end

   assign timer_clk_in_o = tp_sync[TP_TMR_BIT];
   assign capture_compare_two_in_o      = tp_sync[TP_CAPTURE_COMPARE_TWO_BIT];
   assign capture_compare_one_in_o      = tp_sync[TP_CAPTURE_COMPARE_ONE_BIT];
   assign ssp_sck_in_o   = tp_sync[TP_SCK_BIT];
   assign ssp_sdi_o      = tp_sync[TP_SDI_BIT];
   assign usart_ck_in_o  = tp_sync[TP_CK_BIT];
   assign usart_rx_o     = tp_sync[TP_RX_BIT];

   // Fourth port; slave-port strobes live outside, so drivers release
   assign psp_mode_o = fifth_dir[PSP_MODE_BIT];
   assign fp_ttl_o   = (FP_PRESENT != 0) & fifth_dir[PSP_MODE_BIT];
   assign fp_out_o   = fp_latch;
   assign fp_oe_o    = ((FP_PRESENT != 0) && !psp_mode_o) ? ~fp_dir : '0;

   property p_out_excluded;
      @(posedge clk_i) disable iff (!rstn_i)
         (mism & ~sp_dir[CHG_HI:CHG_LO]) == '0;
   endproperty
   a_out_excluded: assert property (p_out_excluded)
      else $error("output pin joined change compare");

   property p_snap_read;
      @(posedge clk_i) disable iff (!rstn_i)
         (rd_first && reg_hit(avs_address_i, IDX_SP_DATA))
         |=> (snap == $past(sp_sync[CHG_HI:CHG_LO])) && (mism == '0 || $changed(sp_sync));
   endproperty
   a_snap_read: assert property (p_snap_read)
      else $error("read did not refresh compare copy");

   property p_flag_set;
      @(posedge clk_i) disable iff (!rstn_i)
         (|mism) |=> flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("mismatch did not set change flag");

   property p_irq;
      @(posedge clk_i) disable iff (!rstn_i)
         ((|mism) && int_ctl[CHG_EN_BIT] && !wr_int) |=> change_irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("wake level wrong");

   property p_snap_write;
      @(posedge clk_i) disable iff (!rstn_i)
         wr_sp |=> snap == $past(sp_sync[CHG_HI:CHG_LO]);
   endproperty
   a_snap_write: assert property (p_snap_write)
      else $error("write did not refresh compare copy");

   property p_set_wins;
      @(posedge clk_i) disable iff (!rstn_i)
         (wr_int && !wbyte[FLAG_BIT] && (|mism)) |=> flag;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a pending mismatch");

   property p_clear;
      @(posedge clk_i) disable iff (!rstn_i)
         (wr_int && !wbyte[FLAG_BIT] && mism == '0) |=> !flag;
   endproperty
   a_clear: assert property (p_clear)
      else $error("software clear lost");

   property p_pullup;
      @(posedge clk_i) disable iff (!rstn_i)
         ((sp_pullup_o & sp_oe_o) == '0) && (!option_ctl[PULL_UP_N_BIT] || sp_pullup_o == '0);
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-ups not on input pins");

   property p_tp_dir;
      @(posedge clk_i) disable iff (!rstn_i)
         (tp_periph_en_i == '0) |-> (tp_oe_o == ~tp_dir) && (tp_out_o == tp_latch);
   endproperty
   a_tp_dir: assert property (p_tp_dir)
      else $error("third-port direction not obeyed");

   property p_override;
      @(posedge clk_i) disable iff (!rstn_i)
         ((tp_oe_o ^ tp_periph_oe_i) & tp_periph_en_i) == '0;
   endproperty
   a_override: assert property (p_override)
      else $error("peripheral override ignored");

   property p_psp;
      @(posedge clk_i) disable iff (!rstn_i)
         psp_mode_o |-> fp_oe_o == '0;
   endproperty
   a_psp: assert property (p_psp)
      else $error("fourth port driven in slave mode");

endmodule : gpc_ports

//--- tb/gpc_pad_model.sv
// Package pin model for one eight-bit port of the general-purpose port block
`timescale 1ns/1ps
module gpc_pad_model (
   // Clock
   input  wire logic       clk_i,
   // Device side
   input  wire logic [7:0] out_i,
   input  wire logic [7:0] oe_i,
   input  wire logic [7:0] pull_i,
   // Board side
   input  wire logic [7:0] ext_val_i,
   input  wire logic [7:0] ext_en_i,
   output logic      [7:0] pin_o
);
   logic [7:0] float_q = 8'h00;

   // Undriven, unpulled pins wander so a stale level never passes
   always @(posedge clk_i) begin
      float_q <= ~float_q;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (oe_i[i])
            pin_o[i] = out_i[i];
         else if (ext_en_i[i])
            pin_o[i] = ext_val_i[i];
         else if (pull_i[i])
            pin_o[i] = 1'b1;
         else
            pin_o[i] = float_q[i];
      end
   end
endmodule : gpc_pad_model

//--- tb/testbench.sv
// Self-checking bench for the general-purpose port block
`timescale 1ns/1ps
module testbench;
   import gpc_pkg::*;
   logic clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, ext_int_en_i, ssp_ss_en_i;
   logic prog_mode_i, ext_int_o, ssp_ss_n_o, prog_clk_o, prog_data_o, change_irq_o, fp_ttl_o;
   logic timer_clk_in_o, capture_compare_two_in_o, capture_compare_one_in_o, ssp_sck_in_o, ssp_sdi_o, usart_ck_in_o;
   logic usart_rx_o, psp_mode_o;
   logic [9:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic [3:0]  avs_byteenable_i;
   logic [1:0]  analog_en_i, analog_connect_o;
   logic [7:0]  sp_in_i, sp_out_o, sp_oe_o, sp_pullup_o, sp_schmitt_o, analog_config_o;
   logic [7:0]  tp_in_i, tp_out_o, tp_oe_o, tp_periph_en_i, tp_periph_oe_i, tp_periph_out_i;
   logic [7:0]  fp_in_i, fp_out_o, fp_oe_o, sp_ext, sp_drv, tp_ext, d, m, p, e_out, e_oe;
   logic [7:0]  exp_q[$];
   int          fails, check_count, cyc;

   gpc_ports #(.FP_PRESENT(1)) u_dut (.clk_i, .rstn_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .sp_in_i, .sp_out_o, .sp_oe_o, .sp_pullup_o, .sp_schmitt_o, .ext_int_en_i, .ssp_ss_en_i,
      .analog_en_i, .prog_mode_i, .ext_int_o, .ssp_ss_n_o, .analog_connect_o, .prog_clk_o,
      .prog_data_o, .analog_config_o, .change_irq_o, .tp_in_i, .tp_out_o, .tp_oe_o,
      .tp_periph_en_i, .tp_periph_oe_i, .tp_periph_out_i, .timer_clk_in_o, .capture_compare_two_in_o,
      .capture_compare_one_in_o, .ssp_sck_in_o, .ssp_sdi_o, .usart_ck_in_o, .usart_rx_o, .fp_in_i,
      .fp_out_o, .fp_oe_o, .fp_ttl_o, .psp_mode_o);
   gpc_pad_model u_sp_pad (.clk_i, .out_i(sp_out_o), .oe_i(sp_oe_o), .pull_i(sp_pullup_o),
      .ext_val_i(sp_ext), .ext_en_i(sp_drv), .pin_o(sp_in_i));
   gpc_pad_model u_tp_pad (.clk_i, .out_i(tp_out_o), .oe_i(tp_oe_o), .pull_i(8'h00),
      .ext_val_i(tp_ext), .ext_en_i(8'hFF), .pin_o(tp_in_i));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic final_report;
      fails += exp_q.size();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] dat);
      @(posedge clk_i);
      avs_address_i   <= {idx, 2'b00};
      avs_read_i      <= ~wr;
      avs_write_i     <= wr;
      avs_writedata_i <= {24'h000000, dat};
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      @(negedge clk_i);
   endtask : bus

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      exp_q.push_back(exp);
      bus(idx, 1'b0, 8'h00);
   endtask : rd

   task automatic wt(input logic [7:0] idx, input logic [7:0] dat);
      bus(idx, 1'b1, dat);
   endtask : wt

   // Read results are judged where they stand, against the oldest note
   always @(posedge clk_i) begin
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
         chk(avs_readdata_o[7:0], exp_q.pop_front());
   end

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end

   initial begin
      {rstn_i, avs_read_i, avs_write_i, ext_int_en_i, ssp_ss_en_i, prog_mode_i} = '0;
      {avs_address_i, avs_writedata_i, analog_en_i, sp_ext, tp_ext, fp_in_i} = '0;
      {tp_periph_en_i, tp_periph_oe_i, tp_periph_out_i} = '0;
      avs_byteenable_i = 4'hF;
      sp_drv = 8'hFF;
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      void'($urandom(32'h60AE));
      rd(IDX_OPTION, 8'hFF);
      rd(IDX_SP_DIR, 8'hFF);
      rd(IDX_TP_DIR, 8'hFF);
      rd(IDX_ANALOG_CFG, 8'h00);
      chk(sp_pullup_o, 8'h00);
      chk(sp_oe_o | tp_oe_o, 8'h00);
      // Outputs random, pull-ups on, one input left undriven and held high by its pull-up
      d = 8'($urandom);
      wt(IDX_SP_DATA, d);
      wt(IDX_SP_DIR, 8'h0F);
      chk(sp_out_o, d);
      chk(sp_oe_o, 8'hF0);
      wt(IDX_OPTION, 8'h7F);
      chk(sp_pullup_o, 8'h0F);
      @(posedge clk_i) sp_drv <= 8'hFE;
      repeat (4) @(negedge clk_i);
      rd(IDX_SP_DATA, {d[7:4], 4'h1});
      wt(IDX_OPTION, 8'hFF);
      @(posedge clk_i) sp_drv <= 8'hFF;
      // Output pins and lower pins stay out of change detection
      wt(IDX_SP_DATA, 8'hFF);
      wt(IDX_SP_DIR, 8'hFF);
      repeat (4) @(negedge clk_i);
      rd(IDX_SP_DATA, 8'h00);
      wt(IDX_INT_CTRL, 8'h08);
      @(posedge clk_i) sp_ext <= 8'h01;
      wt(IDX_SP_DIR, 8'hEF);
      repeat (4) @(negedge clk_i);
      rd(IDX_INT_CTRL, 8'h08);
      rd(IDX_SP_DATA, 8'h11);
      wt(IDX_SP_DIR, 8'hFF);
      @(posedge clk_i) sp_ext <= 8'h00;
      repeat (4) @(negedge clk_i);
      rd(IDX_SP_DATA, 8'h00);
      wt(IDX_INT_CTRL, 8'h08);
      for (int i = 4; i < 8; i++) begin
         @(posedge clk_i) sp_ext <= 8'h01 << i;
         repeat (4) @(negedge clk_i);
         chk({7'h00, change_irq_o}, 8'h01);
         rd(IDX_INT_CTRL, 8'h09);
         wt(IDX_INT_CTRL, 8'h08);
         rd(IDX_INT_CTRL, 8'h09);
         rd(IDX_SP_DATA, 8'h01 << i);
         wt(IDX_INT_CTRL, 8'h08);
         rd(IDX_INT_CTRL, 8'h08);
      end
      @(posedge clk_i) sp_ext <= 8'h00;
      repeat (4) @(negedge clk_i);
      wt(IDX_SP_DATA, 8'h00);
      wt(IDX_INT_CTRL, 8'h08);
      rd(IDX_INT_CTRL, 8'h08);
      // Buffer selection on all eight control combinations, analog sharing on all four enable settings
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i) {prog_mode_i, ssp_ss_en_i, ext_int_en_i} <= 3'(i);
         analog_en_i <= 2'(i);
         @(negedge clk_i);
         chk(sp_schmitt_o, {{2{i[2]}}, 4'h0, i[1:0]});
         chk({6'h00, analog_connect_o}, {6'h00, 2'(i)});
      end
      @(posedge clk_i) sp_ext <= 8'($urandom);
      repeat (4) @(negedge clk_i);
      rd(IDX_SP_DATA, sp_ext & 8'hF3);
      chk({4'h0, prog_data_o, prog_clk_o, ssp_ss_n_o, ext_int_o},
          {4'h0, sp_ext[7:6], sp_ext[1:0]});
      // Third port: peripherals override direction and latch
      for (int i = 0; i < 16; i++) begin
         d = 8'($urandom);
         m = 8'($urandom);
         wt(IDX_TP_DATA, d);
         wt(IDX_TP_DIR, m);
         @(posedge clk_i);
         tp_periph_en_i  <= 8'($urandom);
         tp_periph_oe_i  <= 8'($urandom);
         tp_periph_out_i <= 8'($urandom);
         tp_ext          <= 8'($urandom);
         repeat (4) @(negedge clk_i);
         e_out = (tp_periph_en_i & tp_periph_out_i) | (~tp_periph_en_i & d);
         e_oe  = (tp_periph_en_i & tp_periph_oe_i) | (~tp_periph_en_i & ~m);
         p     = (e_oe & e_out) | (~e_oe & tp_ext);
         chk(tp_out_o, e_out);
         chk(tp_oe_o, e_oe);
         chk({usart_rx_o, usart_ck_in_o, 1'b0, ssp_sdi_o, ssp_sck_in_o, capture_compare_one_in_o, capture_compare_two_in_o,
              timer_clk_in_o}, p & 8'hDF);
         rd(IDX_TP_DATA, p);
      end
      // Fourth port and parallel slave mode
      rd(IDX_FIFTH_DIR, 8'h07);
      wt(IDX_FP_DIR, 8'h0F);
      wt(IDX_FP_DATA, d);
      chk(fp_oe_o, 8'hF0);
      chk(fp_out_o, d);
      chk({6'h00, fp_ttl_o, psp_mode_o}, 8'h00);
      wt(IDX_FIFTH_DIR, 8'h17);
      chk(fp_oe_o, 8'h00);
      chk({6'h00, fp_ttl_o, psp_mode_o}, 8'h03);
      @(posedge clk_i) fp_in_i <= 8'($urandom);
      wt(IDX_ANALOG_CFG, 8'h5A);
      chk(analog_config_o, 8'h5A);
      rd(IDX_FP_DATA, fp_in_i);
      // Refused accesses leave registers alone
      wt(8'hFE, 8'h55);
      rd(8'hFE, 8'h00);
      @(posedge clk_i) avs_byteenable_i <= 4'h0;
      wt(IDX_OPTION, 8'h00);
      @(posedge clk_i) avs_byteenable_i <= 4'hF;
      rd(IDX_OPTION, 8'hFF);
      repeat (4) @(negedge clk_i);
      final_report();
   end
endmodule : testbench
